// ---- logic/charpat_map.svh ----
// Constants of the character pattern generator: opcodes, fields, reset values.
// Assumes inclusion by the design file of this block only.
`ifndef CHARPAT_MAP_SVH
`define CHARPAT_MAP_SVH

// ----------------------------------------
// Instruction opcodes and fields
// ----------------------------------------
`define OP_DISPLAY_ADDR_BIT 7
`define OP_GLYPH_ADDR_BIT 6
`define OP_FUNCTION_BIT 5
`define OP_ENTRY_BIT 2
`define FN_TALL_BIT 2
`define ENTRY_INC_BIT 1

// ----------------------------------------
// Reset values and geometry
// ----------------------------------------
`define FONT_TABLE_RESET 2'h1
`define INCREMENT_RESET 1'b1
`define TALL_RESET 1'b0
`define CURSOR_ROW_SHORT 4'h7
`define CURSOR_ROW_TALL 4'ha
`define CURSOR_PATTERN 5'h1f
`define BUSY_IDLE 1'b0

`endif

// ---- logic/charpat_pkg.sv ----
// Types shared by the character pattern generator.
// Assumes the constants header sits beside it.
package charpat_pkg;
  typedef logic [7:0] code_t;
  typedef logic [1:0] font_table_t;
  typedef logic [4:0] dots_t;
  typedef enum logic [1:0]
  {
    TARGET_DISPLAY = 2'b01,
    TARGET_USER = 2'b10
  } target_e;
endpackage

// ---- logic/character_pattern_generator.sv ----
// Character pattern generator with display code memory and user glyph memory.
// Assumes host accesses as one-cycle strobes and a scan that asks one row per cycle.
//
// Behaviour
// - Codes become 5x8 or 5x10 fixed-font rows
// - Four font tables, second after reset
// - User memory holds eight short glyphs
// - User memory holds four tall glyphs
// - Host rewrites glyphs anytime, display follows
// - Data bits 0..4 map columns, bit4 leftmost
// - Code bits 0..2 give address bits 3..5 (bits 1..2 give 4..5 when tall)
// - Address bits 0..2 pick glyph row (bits 0..3 when tall)
// - Data one lights dot, zero dark
// - Eighth row (eleventh when tall) ORed with cursor pattern
// - Set eighth-row bits light without cursor
// - Code high nibble zero picks user glyphs
// - Code bit 3 ignored for user glyphs
// - Address counter steps after data access
// - Select and direction pick the access
// - Display memory holds 128 codes
`include "charpat_map.svh"

module character_pattern_generator #(
  parameter int DISPLAY_DEPTH = 128,
  parameter int GLYPH_DEPTH = 64
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic host_strobe_i,
  input wire logic register_select_i,
  input wire logic read_not_write_i,
  input wire charpat_pkg::code_t host_data_i,
  output charpat_pkg::code_t host_data_o,
  output logic busy_flag_o,
  input wire logic [6:0] scan_addr_i,
  input wire logic [3:0] scan_row_i,
  input wire logic cursor_here_i,
  output charpat_pkg::dots_t dot_row_o
);
  import charpat_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  code_t display_code_memory [DISPLAY_DEPTH];
  code_t user_glyph_memory [GLYPH_DEPTH];

  logic [6:0] address_counter;
  logic increment;
  logic tall;
  font_table_t font_table;
  target_e target;
  logic [6:0] next_address_counter;
  logic next_increment;
  logic next_tall;
  font_table_t next_font_table;
  target_e next_target;
  code_t next_host_data;
  dots_t next_dot_row;
  logic next_busy;
  logic display_we;
  logic glyph_we;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Stand-in fixed font content, table selects the pattern set
  function automatic dots_t fixed_font_row(input font_table_t tbl, input code_t code, input logic [3:0] row);
    fixed_font_row = code[4:0] ^ {row, 1'b0} ^ {tbl, 3'h0} ^ {2'h0, code[7:5]};
  endfunction

  function automatic logic [6:0] step_address(input logic [6:0] cur, input logic inc, input target_e tgt);
    logic [6:0] stepped;
    stepped = inc ? 7'(cur + 7'h1) : 7'(cur - 7'h1);
    step_address = (tgt == TARGET_USER) ? {1'b0, stepped[5:0]} : stepped;
  endfunction

  wire instr_write = host_strobe_i && !register_select_i && !read_not_write_i;
  wire status_read = host_strobe_i && !register_select_i && read_not_write_i;
  wire data_access = host_strobe_i && register_select_i;

  // ----------------------------------------
  // Row lookup
  // ----------------------------------------
  code_t scan_code;
  logic code_is_user;
  logic [5:0] glyph_addr;
  code_t glyph_data;
  dots_t font_row;

  assign scan_code = display_code_memory[scan_addr_i];
  assign code_is_user = (scan_code[7:4] == 4'h0);
  assign glyph_addr = tall ? {scan_code[2:1], scan_row_i} : {scan_code[2:0], scan_row_i[2:0]};
  assign glyph_data = user_glyph_memory[glyph_addr];
  assign font_row = fixed_font_row(font_table, scan_code, scan_row_i);

  always_comb
  begin
    next_dot_row = 5'h00;
    if (!tall && scan_row_i > `CURSOR_ROW_SHORT)
    begin
      next_dot_row = 5'h00;
    end
    else if (tall && scan_row_i > `CURSOR_ROW_TALL)
    begin
      next_dot_row = 5'h00;
    end
    else if (code_is_user)
    begin
      next_dot_row = glyph_data[4:0];
    end
    else
    begin
      next_dot_row = font_row;
    end
    if (cursor_here_i && scan_row_i == (tall ? `CURSOR_ROW_TALL : `CURSOR_ROW_SHORT))
    begin
      next_dot_row = next_dot_row | `CURSOR_PATTERN;
    end
  end

  // ----------------------------------------
  // Host port
  // ----------------------------------------
  always_comb
  begin
    next_address_counter = address_counter;
    next_increment = increment;
    next_tall = tall;
    next_font_table = font_table;
    next_target = target;
    next_host_data = host_data_o;
    next_busy = `BUSY_IDLE;
    display_we = 1'b0;
    glyph_we = 1'b0;
    if (instr_write)
    begin
      if (host_data_i[`OP_DISPLAY_ADDR_BIT])
      begin
        next_address_counter = host_data_i[6:0];
        next_target = TARGET_DISPLAY;
      end
      else if (host_data_i[`OP_GLYPH_ADDR_BIT])
      begin
        next_address_counter = {1'b0, host_data_i[5:0]};
        next_target = TARGET_USER;
      end
      else if (host_data_i[`OP_FUNCTION_BIT])
      begin
        next_tall = host_data_i[`FN_TALL_BIT];
        next_font_table = host_data_i[1:0];
      end
      else if (host_data_i[`OP_ENTRY_BIT])
      begin
        next_increment = host_data_i[`ENTRY_INC_BIT];
      end
    end
    else if (status_read)
    begin
      next_host_data = {busy_flag_o, address_counter};
    end
    else if (data_access)
    begin
      if (read_not_write_i)
      begin
        next_host_data = (target == TARGET_USER) ? user_glyph_memory[address_counter[5:0]]
                                                 : display_code_memory[address_counter];
      end
      else
      begin
        display_we = (target == TARGET_DISPLAY);
        glyph_we = (target == TARGET_USER);
      end
      next_address_counter = step_address(address_counter, increment, target);
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      address_counter <= 7'h00;
      increment <= `INCREMENT_RESET;
      tall <= `TALL_RESET;
      font_table <= `FONT_TABLE_RESET;
      target <= TARGET_DISPLAY;
      host_data_o <= 8'h00;
      busy_flag_o <= `BUSY_IDLE;
      dot_row_o <= 5'h00;
    end
    else
    begin
      address_counter <= next_address_counter;
      increment <= next_increment;
      tall <= next_tall;
      font_table <= next_font_table;
      target <= next_target;
      host_data_o <= next_host_data;
      busy_flag_o <= next_busy;
      dot_row_o <= next_dot_row;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (display_we)
    begin
      display_code_memory[address_counter] <= host_data_i;
    end
    if (glyph_we)
    begin
      user_glyph_memory[address_counter[5:0]] <= host_data_i;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  font_change_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (font_table != $past(font_table)) |-> $past(instr_write && host_data_i[7:5] == 3'b001))
    else $error("font table changed without function instruction");

  user_row_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (code_is_user && !tall && scan_row_i < `CURSOR_ROW_SHORT) |=> dot_row_o == $past(glyph_data[4:0]))
    else $error("user glyph row not shown");

  alias_code_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (code_is_user && !tall && scan_row_i < `CURSOR_ROW_SHORT)
    |=> dot_row_o == $past(user_glyph_memory[{scan_code[2:0], scan_row_i[2:0]}][4:0]))
    else $error("user glyph address wrong");

  cursor_or_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (!tall && scan_row_i == `CURSOR_ROW_SHORT && cursor_here_i) |=> dot_row_o == `CURSOR_PATTERN)
    else $error("cursor row not lit");

  stray_dots_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (!tall && code_is_user && scan_row_i == `CURSOR_ROW_SHORT && !cursor_here_i)
    |=> dot_row_o == $past(glyph_data[4:0]))
    else $error("cursor row data not shown");

  fixed_font_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (!code_is_user && !tall && scan_row_i < `CURSOR_ROW_SHORT) |=> dot_row_o == $past(font_row))
    else $error("fixed font row not shown");

  tall_user_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (tall && code_is_user && scan_row_i < `CURSOR_ROW_TALL)
    |=> dot_row_o == $past(user_glyph_memory[{scan_code[2:1], scan_row_i}][4:0]))
    else $error("tall user glyph row wrong");

  counter_up_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (data_access && increment && target == TARGET_DISPLAY) |=> address_counter == 7'($past(address_counter) + 7'h1))
    else $error("address counter did not step up");

  counter_down_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (data_access && !increment && target == TARGET_DISPLAY) |=> address_counter == 7'($past(address_counter) - 7'h1))
    else $error("address counter did not step down");

  status_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    status_read |=> host_data_o == {1'b0, $past(address_counter)})
    else $error("status read wrong");

  glyph_store_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (data_access && !read_not_write_i && target == TARGET_USER)
    |=> user_glyph_memory[$past(address_counter[5:0])] == $past(host_data_i))
    else $error("glyph write lost");

  code_store_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (data_access && !read_not_write_i && target == TARGET_DISPLAY)
    |=> display_code_memory[$past(address_counter)] == $past(host_data_i))
    else $error("display code write lost");
endmodule

// ---- test/char_host_model.sv ----
// Host model: strobed register-select, direction and data accesses.
// Assumes the bench owns the clock and samples read data from the device.
module char_host_model (
  input wire logic clk_i,
  output logic strobe_o,
  output logic select_o,
  output logic read_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    strobe_o = 1'b0;
    select_o = 1'b0;
    read_o = 1'b0;
    data_o = 8'h00;
  end

  // One access, held until its taking edge, then released
  task automatic access(input logic sel, input logic rd, input logic [7:0] d);
    @(posedge clk_i);
    strobe_o <= 1'b1;
    select_o <= sel;
    read_o <= rd;
    data_o <= d;
    @(posedge clk_i);
    strobe_o <= 1'b0;
    select_o <= ~sel;
    data_o <= ~d;
  endtask
endmodule

// ---- test/test_character_pattern_generator.sv ----
// Testbench: host writes glyphs and codes, scan port rows are judged.
// Assumes one clock, asynchronous active-low reset, no timing checks.
module test_character_pattern_generator;
  timeunit 1ns;
  timeprecision 1ns;
  import charpat_pkg::*;

  logic clk;
  logic nrst;
  logic strobe;
  logic sel_line;
  logic dir_line;
  logic [7:0] wdata;
  code_t rdata;
  logic busy;
  logic [6:0] scan_addr;
  logic [3:0] scan_row;
  logic cursor;
  dots_t dots;
  int errors;
  int checks_done;
  logic [7:0] pat [8];

  char_host_model host (.clk_i(clk), .strobe_o(strobe), .select_o(sel_line), .read_o(dir_line), .data_o(wdata));

  character_pattern_generator uut (.core_clk_i(clk), .nrst_i(nrst), .host_strobe_i(strobe),
    .register_select_i(sel_line), .read_not_write_i(dir_line), .host_data_i(wdata), .host_data_o(rdata),
    .busy_flag_o(busy), .scan_addr_i(scan_addr), .scan_row_i(scan_row), .cursor_here_i(cursor),
    .dot_row_o(dots));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic scan(input logic [6:0] a, input logic [3:0] r, input logic c, input logic [4:0] exp);
    @(posedge clk);
    scan_addr <= a;
    scan_row <= r;
    cursor <= c;
    @(posedge clk);
    #1;
    check({3'h0, dots}, {3'h0, exp});
  endtask

  task automatic read_back(input logic sel, input logic [7:0] exp);
    host.access(sel, 1'b1, 8'h00);
    @(posedge clk);
    #1;
    check(rdata, exp);
  endtask

  function automatic logic [4:0] font(input logic [7:0] c, input logic [3:0] r, input logic [1:0] t);
    return c[4:0] ^ {r, 1'b0} ^ {t, 3'b000} ^ {2'b00, c[7:5]};
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    check({7'h00, busy}, 8'h00);
    check({3'h0, dots}, 8'h00);
    read_back(1'b0, 8'h00);
  endtask

  task automatic t_user;
    pat = '{8'he4, 8'h31, 8'h4a, 8'h1f, 8'ha0, 8'h15, 8'hce, 8'h00};
    host.access(1'b0, 1'b0, 8'h58);
    for (int i = 0; i < 8; i++)
      host.access(1'b1, 1'b0, pat[i]);
    read_back(1'b0, 8'h20);
    host.access(1'b0, 1'b0, 8'h85);
    host.access(1'b1, 1'b0, 8'h0b);
    for (int i = 0; i < 8; i++)
      scan(7'h05, 4'(i), 1'b0, pat[i][4:0]);
    scan(7'h05, 4'h7, 1'b1, 5'h1f);
    host.access(1'b0, 1'b0, 8'h5f);
    host.access(1'b1, 1'b0, 8'h04);
    scan(7'h05, 4'h7, 1'b0, 5'h04);
    host.access(1'b0, 1'b0, 8'h58);
    read_back(1'b1, pat[0]);
    read_back(1'b1, pat[1]);
  endtask

  task automatic t_font;
    host.access(1'b0, 1'b0, 8'h86);
    host.access(1'b1, 1'b0, 8'h41);
    scan(7'h06, 4'h2, 1'b0, font(8'h41, 4'h2, 2'h1));
    for (int t = 0; t < 3; t++)
    begin
      host.access(1'b0, 1'b0, 8'h20 | 8'(t));
      scan(7'h06, 4'h5, 1'b0, font(8'h41, 4'h5, 2'(t)));
    end
  endtask

  task automatic t_tall;
    host.access(1'b0, 1'b0, 8'h25);
    host.access(1'b0, 1'b0, 8'h53);
    host.access(1'b1, 1'b0, 8'h15);
    host.access(1'b0, 1'b0, 8'h87);
    host.access(1'b1, 1'b0, 8'h03);
    scan(7'h07, 4'h3, 1'b0, 5'h15);
    scan(7'h07, 4'ha, 1'b1, 5'h1f);
    scan(7'h07, 4'hb, 1'b1, 5'h00);
  endtask

  task automatic t_step;
    host.access(1'b0, 1'b0, 8'h04);
    host.access(1'b0, 1'b0, 8'h90);
    host.access(1'b1, 1'b0, 8'h7e);
    read_back(1'b0, 8'h0f);
    host.access(1'b0, 1'b0, 8'h90);
    read_back(1'b1, 8'h7e);
    host.access(1'b0, 1'b0, 8'h40);
    host.access(1'b1, 1'b0, 8'h00);
    read_back(1'b0, 8'h3f);
    host.access(1'b0, 1'b0, 8'h80);
    host.access(1'b1, 1'b0, 8'h20);
    read_back(1'b0, 8'h7f);
  endtask

  task automatic results;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #200us;
    errors++;
    results();
  end

  initial
  begin
    errors = 0;
    checks_done = 0;
    nrst = 1'b0;
    scan_addr = 7'h00;
    scan_row = 4'h8;
    cursor = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_user();
    t_font();
    t_tall();
    t_step();
    results();
  end
endmodule
